// >>> spmp_pkg.sv
`default_nettype none
package spmp_pkg;
    // ---------------------------------------------------------------
    // Word sizes and memory map
    // ---------------------------------------------------------------
    localparam int          CMD_W      = 6;
    localparam int          WORD_W     = 14;
    localparam int          PC_W       = 14;
    localparam int          PROG_AW    = 11;
    localparam int          PROG_DEPTH = 2048;
    localparam int          BITCNT_W   = 4;
    localparam int          PIN_W      = 4;
    localparam logic [13:0] PC_ENTRY   = 14'h0000;
    localparam logic [13:0] ID_BASE    = 14'h2000;
    localparam logic [13:0] ID_LAST    = 14'h2003;
    localparam logic [13:0] CFG_ADDR   = 14'h2007;
    localparam logic [13:0] BLANK_WORD = 14'h3FFF;
    localparam logic [13:0] CFG_RESET  = 14'h3FFF;
    localparam logic [13:0] PROT_WORD  = 14'h0000;
    localparam logic [2:0]  PROG_HI    = 3'h0;
    localparam logic [10:0] CLR_LAST   = 11'h7FF;
    // ---------------------------------------------------------------
    // Code protection field of the configuration word
    // ---------------------------------------------------------------
    localparam int          CP_LSB     = 4;
    localparam logic [1:0]  CP_OFF     = 2'h3;
    // ---------------------------------------------------------------
    // Serial commands and bit counts
    // ---------------------------------------------------------------
    localparam logic [5:0]  CMD_LOAD_CFG   = 6'h00;
    localparam logic [5:0]  CMD_LOAD_DATA  = 6'h02;
    localparam logic [5:0]  CMD_READ_DATA  = 6'h04;
    localparam logic [5:0]  CMD_INC_ADDR   = 6'h06;
    localparam logic [5:0]  CMD_BEGIN_PROG = 6'h08;
    localparam logic [5:0]  CMD_ERASE      = 6'h09;
    localparam logic [3:0]  LAST_CMD_BIT   = 4'h5;
    localparam logic [3:0]  LAST_DATA_BIT  = 4'hD;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {LNK_CMD, LNK_DIN, LNK_GAP, LNK_DOUT} spmp_lnk_e;
    typedef struct packed {
        logic [5:0]  cmd;
        logic [13:0] data;
    } spmp_xact_s;
    typedef struct packed {
        logic hv;
        logic clk;
        logic dat;
        logic tgl;
    } spmp_pins_s;
endpackage
`default_nettype wire

// >>> spmp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module spmp_sync (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Asynchronous levels in, filtered levels out
    input  wire spmp_pkg::spmp_pins_s     d,
    output var spmp_pkg::spmp_pins_s      q
);
    import spmp_pkg::*;

    typedef struct packed {
        spmp_pins_s s1;
        spmp_pins_s s2;
        spmp_pins_s s3;
        spmp_pins_s q;
    } spmp_sync_s;

    spmp_sync_s r_reg;
    spmp_sync_s r_next;

    // A level counts only once the second and third stages agree
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.q  = (r_reg.s3 & ~(r_reg.s2 ^ r_reg.s3))
                  | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.q;
endmodule
`default_nettype wire

// >>> spmp_link.sv
`timescale 1ns/100ps
`default_nettype none
module spmp_link (
    // Programmer clock and session clear
    input  wire logic                     link_clk,
    input  wire logic                     link_arst_n,
    // Data pin
    input  wire logic                     dat_in,
    output logic                          dat_out,
    output logic                          dat_oe,
    // Transfer to and from the core
    output var spmp_pkg::spmp_xact_s      xact,
    output logic                          xact_tgl,
    input  wire logic [13:0]              rd_word
);
    import spmp_pkg::*;

    typedef struct packed {
        spmp_lnk_e    st;
        logic [3:0]   cnt;
        logic [5:0]   cmd;
        logic [13:0]  sh;
        spmp_xact_s   xact;
        logic         tgl;
        logic         dout;
        logic         oe;
    } spmp_link_s;

    spmp_link_s r_reg;
    spmp_link_s r_next;
    logic [5:0] cmd_now;
    logic [13:0] sh_now;

    assign cmd_now = {dat_in, r_reg.cmd[5:1]};
    assign sh_now  = {dat_in, r_reg.sh[13:1]};

    always_comb begin
        r_next     = r_reg;
        r_next.cnt = r_reg.cnt + 4'h1;
        case (r_reg.st)
            LNK_CMD: begin
                r_next.cmd = cmd_now;
                if (r_reg.cnt == LAST_CMD_BIT) begin
                    r_next.cnt = '0;
                    if (cmd_now == CMD_LOAD_CFG ||
                        cmd_now == CMD_LOAD_DATA) begin
                        r_next.st = LNK_DIN;
                    end else begin
                        r_next.xact = '{cmd: cmd_now, data: '0};
                        r_next.tgl  = ~r_reg.tgl;
                        if (cmd_now == CMD_READ_DATA) begin
                            r_next.st = LNK_GAP;
                        end
                    end
                end
            end
            LNK_DIN: begin
                r_next.sh = sh_now;
                if (r_reg.cnt == LAST_DATA_BIT) begin
                    r_next.cnt  = '0;
                    r_next.xact = '{cmd: r_reg.cmd, data: sh_now};
                    r_next.tgl  = ~r_reg.tgl;
                    r_next.st   = LNK_CMD;
                end
            end
            LNK_GAP: begin
                // The idle period gives the core time to fetch the word;
                // it is quasi-static by the time it is loaded here
                r_next.cnt  = '0;
                r_next.dout = rd_word[0];
                r_next.sh   = {1'b0, rd_word[13:1]};
                r_next.oe   = 1'b1;
                r_next.st   = LNK_DOUT;
            end
            LNK_DOUT: begin
                if (r_reg.cnt == LAST_DATA_BIT) begin
                    r_next.cnt  = '0;
                    r_next.oe   = 1'b0;
                    r_next.dout = 1'b0;
                    r_next.st   = LNK_CMD;
                end else begin
                    r_next.dout = r_reg.sh[0];
                    r_next.sh   = {1'b0, r_reg.sh[13:1]};
                end
            end
            default: begin
                r_next = '0;
            end
        endcase
    end

    // Cleared while out of session; the programmer holds its clock low
    // across the release, so no edge races it
    always_ff @(posedge link_clk or negedge link_arst_n) begin
        if (!link_arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign dat_out  = r_reg.dout;
    assign dat_oe   = r_reg.oe;
    assign xact     = r_reg.xact;
    assign xact_tgl = r_reg.tgl;

    default clocking @(posedge link_clk); endclocking
    default disable iff (!link_arst_n);

    oe_window_a: assert property (
        (r_reg.st == LNK_GAP) |=> dat_oe [*8] ##1 dat_oe [*6] ##1 !dat_oe)
        else $error("read driver window is not fourteen periods");
    din_length_a: assert property (
        (r_reg.st == LNK_DIN && r_reg.cnt == 4'h0) |->
        ##13 (r_reg.st == LNK_DIN) ##1 (r_reg.st == LNK_CMD && $changed(xact_tgl)))
        else $error("load word is not fourteen bits");
    cmd_length_a: assert property (
        (r_reg.st == LNK_CMD && r_reg.cnt == 4'h0) |->
        ##5 (r_reg.cnt == LAST_CMD_BIT) ##1 (r_reg.cnt == 4'h0))
        else $error("command is not six bits");
endmodule
`default_nettype wire

// >>> spmp_top.sv
// Functional notes
// - Entry: clock and data pins low while master clear rises to high level.
// - In session the clock pin clocks the link and data pin carries bits.
// - Data line driven by programmer on loads, by device on reads only.
// - Pins are filtered for entry and exit decode, raw into the link; data drives push-pull only while returning.
// - Program counter is zero on entry, before any command.
// - Every operation starts with a six-bit command from the programmer.
// - Loads carry fourteen bits in, reads fourteen bits out, others none.
// - Watchdog cannot reset the device while the session is active.
// - Four ID words at 2000h to 2003h, writable and readable in session.
// - ID words are never reachable by normal program fetches.
// - Protected program memory reads back as all zero words.
// - Erase blanks program memory and leaves the configuration word.
`timescale 1ns/100ps
`default_nettype none
module spmp_top (
    // Core clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST,
    // Programming pins
    input  wire logic                          MASTER_CLEAR_PIN_HV,
    input  wire logic                          PROG_CLK,
    input  wire logic                          PROG_DAT_IN,
    output logic                               PROG_DAT_OUT,
    output logic                               PROG_DAT_OE,
    // Session status
    output logic                               PROG_MODE,
    // Watchdog
    input  wire logic                          WDT_TIMEOUT,
    output logic                               WDT_RESET,
    // Normal execution fetch
    input  wire logic [spmp_pkg::PROG_AW-1:0]  FETCH_ADDR,
    output logic [spmp_pkg::WORD_W-1:0]        FETCH_WORD
);
    import spmp_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic                    mode;
        logic                    hv_prev;
        logic [PC_W-1:0]         pc;
        logic [WORD_W-1:0]       latch;
        logic [WORD_W-1:0]       rd_word;
        logic                    seen_tgl;
        logic [WORD_W-1:0]       cfg;
        logic [3:0][WORD_W-1:0]  id;
        logic                    clr;
        logic [PROG_AW-1:0]      clr_addr;
        logic                    wdt_rst;
        logic [WORD_W-1:0]       fetch;
    } spmp_core_s;

    spmp_core_s         r_reg;
    spmp_core_s         r_next;
    logic [WORD_W-1:0]  prog_mem [PROG_DEPTH];
    logic               mem_we;
    logic [PROG_AW-1:0] mem_waddr;
    logic [WORD_W-1:0]  mem_wdata;

    spmp_pins_s         pins_raw;
    spmp_pins_s         pins_q;
    spmp_xact_s         xact;
    logic               xact_tgl;
    logic               link_dout;
    logic               link_oe;

    logic               hv_rise;
    logic               xact_new;
    logic               pc_in_prog;
    logic               pc_in_id;
    logic               cp_on;

    // ---------------------------------------------------------------
    // Crossings into the core clock
    // ---------------------------------------------------------------
    assign pins_raw = '{hv: MASTER_CLEAR_PIN_HV, clk: PROG_CLK, dat: PROG_DAT_IN,
                        tgl: xact_tgl};

    // Pin levels pass the same filter as the toggle, acting as the
    // hysteresis stage for entry and exit decode only; the link takes clock and data raw
    spmp_sync u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (pins_raw),
        .q   (pins_q)
    );

    // ---------------------------------------------------------------
    // Link side, clocked by the programmer
    // ---------------------------------------------------------------
    spmp_link u_link (
        .link_clk    (PROG_CLK),
        .link_arst_n (r_reg.mode),
        .dat_in      (PROG_DAT_IN),
        .dat_out     (link_dout),
        .dat_oe      (link_oe),
        .xact        (xact),
        .xact_tgl    (xact_tgl),
        .rd_word     (r_reg.rd_word)
    );

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    assign hv_rise    = pins_q.hv && !r_reg.hv_prev;
    assign xact_new   = (pins_q.tgl != r_reg.seen_tgl) && r_reg.mode
                      && !r_reg.clr;
    assign pc_in_prog = (r_reg.pc[PC_W-1:PROG_AW] == PROG_HI);
    assign pc_in_id   = (r_reg.pc >= ID_BASE) && (r_reg.pc <= ID_LAST);
    assign cp_on      = (r_reg.cfg[CP_LSB+1:CP_LSB] != CP_OFF);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        r_next         = r_reg;
        mem_we         = 1'b0;
        mem_waddr      = r_reg.pc[PROG_AW-1:0];
        mem_wdata      = r_reg.latch;
        r_next.hv_prev = pins_q.hv;

        // Entry needs both pins low on the rise; leaving is on the fall
        if (hv_rise && !pins_q.clk && !pins_q.dat && !r_reg.mode) begin
            r_next.mode     = 1'b1;
            r_next.pc       = PC_ENTRY;
            r_next.seen_tgl = 1'b0;
        end else if (!pins_q.hv) begin
            r_next.mode = 1'b0;
        end

        if (xact_new) begin
            r_next.seen_tgl = pins_q.tgl;
            case (xact.cmd)
                CMD_LOAD_CFG: begin
                    r_next.pc    = ID_BASE;
                    r_next.latch = xact.data;
                end
                CMD_LOAD_DATA: begin
                    r_next.latch = xact.data;
                end
                CMD_READ_DATA: begin
                    if (pc_in_prog) begin
                        // Protected memory yields zeros, never contents
                        r_next.rd_word = cp_on ? PROT_WORD
                                       : prog_mem[r_reg.pc[PROG_AW-1:0]];
                    end else if (pc_in_id) begin
                        r_next.rd_word = r_reg.id[r_reg.pc[1:0]];
                    end else if (r_reg.pc == CFG_ADDR) begin
                        r_next.rd_word = r_reg.cfg;
                    end else begin
                        r_next.rd_word = BLANK_WORD;
                    end
                end
                CMD_INC_ADDR: begin
                    r_next.pc = r_reg.pc + 14'h0001;
                end
                CMD_BEGIN_PROG: begin
                    if (pc_in_prog) begin
                        mem_we = 1'b1;
                    end else if (pc_in_id) begin
                        r_next.id[r_reg.pc[1:0]] = r_reg.latch;
                    end else if (r_reg.pc == CFG_ADDR) begin
                        r_next.cfg = r_reg.latch;
                    end
                end
                CMD_ERASE: begin
                    // Configuration word is left as it is
                    r_next.clr      = 1'b1;
                    r_next.clr_addr = '0;
                end
                default: begin
                    r_next.latch = r_reg.latch;
                end
            endcase
        end

        // One word per cycle; new commands wait in the toggle meanwhile
        if (r_reg.clr) begin
            mem_we          = 1'b1;
            mem_waddr       = r_reg.clr_addr;
            mem_wdata       = BLANK_WORD;
            r_next.clr_addr = r_reg.clr_addr + 11'h001;
            if (r_reg.clr_addr == CLR_LAST) begin
                r_next.clr = 1'b0;
            end
        end

        r_next.wdt_rst = WDT_TIMEOUT && !r_reg.mode;
        // Fetch port has only program memory address bits
        r_next.fetch   = prog_mem[FETCH_ADDR];
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            r_reg          <= '0;
            r_reg.pc       <= PC_ENTRY;
            r_reg.cfg      <= CFG_RESET;
            r_reg.clr      <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (mem_we) begin
            prog_mem[mem_waddr] <= mem_wdata;
        end
    end

    assign PROG_DAT_OUT = link_dout;
    assign PROG_DAT_OE  = link_oe;
    assign PROG_MODE    = r_reg.mode;
    assign WDT_RESET    = r_reg.wdt_rst;
    assign FETCH_WORD   = r_reg.fetch;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence entry_seen;
        hv_rise && !pins_q.clk && !pins_q.dat && !r_reg.mode;
    endsequence

    sequence session_open;
        r_reg.mode && r_reg.pc == PC_ENTRY;
    endsequence

    entry_start_a: assert property (
        entry_seen |=> session_open)
        else $error("entry did not open session at address zero");
    entry_cause_a: assert property (
        $rose(r_reg.mode) |-> $past(hv_rise) && !$past(pins_q.clk))
        else $error("session opened without the entry condition");
    mode_exit_a: assert property (
        (r_reg.mode && !pins_q.hv) |=> !r_reg.mode ##1 !PROG_MODE)
        else $error("session did not close on master clear fall");
    wdt_blocked_a: assert property (
        (r_reg.mode && WDT_TIMEOUT) |=> !WDT_RESET)
        else $error("watchdog reset escaped during session");
    wdt_passed_a: assert property (
        (!r_reg.mode && WDT_TIMEOUT) |=> WDT_RESET)
        else $error("watchdog reset lost outside session");
    id_write_a: assert property (
        (xact_new && xact.cmd == CMD_BEGIN_PROG && pc_in_id) |=>
        r_reg.id[$past(r_reg.pc[1:0])] == $past(r_reg.latch))
        else $error("ID word not written");
    prot_read_a: assert property (
        (xact_new && xact.cmd == CMD_READ_DATA && pc_in_prog && cp_on)
        |=> r_reg.rd_word == PROT_WORD)
        else $error("protected read returned contents");
    erase_cfg_a: assert property (
        (xact_new && xact.cmd == CMD_ERASE) |=>
        r_reg.clr && r_reg.cfg == $past(r_reg.cfg) ##1 mem_we)
        else $error("erase touched configuration or did not start");
    load_cfg_pc_a: assert property (
        (xact_new && xact.cmd == CMD_LOAD_CFG) |=> r_reg.pc == ID_BASE)
        else $error("load configuration did not point at ID base");
endmodule
`default_nettype wire

// >>> spmp_prog_model.sv
`timescale 1ns/100ps
`default_nettype none
module spmp_prog_model (
    // Pins driven by the programmer
    output logic      hv,
    output logic      pclk,
    output var logic  pdat,
    // Device side of the data pin
    input  wire logic dev_out,
    input  wire logic dev_oe
);
    logic own_en;
    logic drv;
    int   faults;

    // Released line shows the inverse of its last level, never a held value
    assign pdat = dev_oe ? dev_out : drv;

    initial begin
        hv = 1'b0;
        pclk = 1'b0;
        drv = 1'b0;
        own_en = 1'b1;
        faults = 0;
    end

    // Both parties driving at once is a fault
    always @(posedge pclk) begin
        if (own_en && dev_oe) begin
            faults++;
        end
    end

    // Clock only runs inside a frame; data changes after the falling edge
    task automatic edge_pair();
        #32 pclk = 1'b1;
        #32 pclk = 1'b0;
    endtask

    task automatic send_bit(input logic b);
        own_en = 1'b1;
        drv = b;
        edge_pair();
    endtask

    task automatic enter(input logic dat);
        drv = dat;
        #100 hv = 1'b1;
        #150;
    endtask

    task automatic leave();
        hv = 1'b0;
        #150;
        drv = 1'b0;
    endtask

    // Mode 0: command only, 1: load, 2: read
    task automatic xfer(input logic [5:0] cmd, input logic [13:0] din,
                        input int mode, output logic [13:0] dout);
        dout = 14'h0000;
        #13.7;
        for (int i = 0; i < 6; i++) begin
            send_bit(cmd[i]);
        end
        if (mode == 1) begin
            for (int i = 0; i < 14; i++) begin
                send_bit(din[i]);
            end
        end
        if (mode == 2) begin
            own_en = 1'b0;
            drv = ~drv;
            for (int i = 0; i < 14; i++) begin
                edge_pair();
                if (dev_oe !== 1'b1) begin
                    faults++;
                end
                dout[i] = pdat;
            end
            edge_pair();
            if (dev_oe !== 1'b0) begin
                faults++;
            end
            own_en = 1'b1;
            drv = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> spmp_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spmp_top_tb;
    import spmp_pkg::*;
    logic             CLK;
    logic             RST;
    logic             WDT_TIMEOUT;
    logic [10:0]      FETCH_ADDR;
    wire logic        MASTER_CLEAR_PIN_HV;
    wire logic        PROG_CLK;
    wire logic        PROG_DAT_IN;
    wire logic        PROG_DAT_OUT;
    wire logic        PROG_DAT_OE;
    wire logic        PROG_MODE;
    wire logic        WDT_RESET;
    wire logic [13:0] FETCH_WORD;
    int               num_errors;
    int               compares;
    int               cycles;
    int               exp_mem[int];
    logic [13:0]      rd;
    logic [13:0]      cfg;
    logic [13:0]      ids[4];

    spmp_prog_model prog (.hv(MASTER_CLEAR_PIN_HV), .pclk(PROG_CLK), .pdat(PROG_DAT_IN),
        .dev_out(PROG_DAT_OUT), .dev_oe(PROG_DAT_OE));
    spmp_top DUT (.CLK(CLK), .RST(RST), .MASTER_CLEAR_PIN_HV(MASTER_CLEAR_PIN_HV),
        .PROG_CLK(PROG_CLK), .PROG_DAT_IN(PROG_DAT_IN),
        .PROG_DAT_OUT(PROG_DAT_OUT), .PROG_DAT_OE(PROG_DAT_OE),
        .PROG_MODE(PROG_MODE), .WDT_TIMEOUT(WDT_TIMEOUT),
        .WDT_RESET(WDT_RESET), .FETCH_ADDR(FETCH_ADDR),
        .FETCH_WORD(FETCH_WORD));

    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    // Hang guard, well above the expected run of some 13300 cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [13:0] e,
                            input logic [13:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask

    task automatic rd_chk(input string nm, input logic [13:0] e);
        prog.xfer(CMD_READ_DATA, 14'h0000, 2, rd);
        chk_word(nm, e, rd);
    endtask

    task automatic wr(input logic [5:0] cmd, input logic [13:0] d);
        prog.xfer(cmd, d, 1, rd);
        prog.xfer(CMD_BEGIN_PROG, 14'h0000, 0, rd);
    endtask

    task automatic step(input int n);
        repeat (n) prog.xfer(CMD_INC_ADDR, 14'h0000, 0, rd);
    endtask

    task automatic fetch_chk(input int a, input logic [13:0] e);
        @(negedge CLK);
        FETCH_ADDR = 11'(a);
        cyc(2);
        chk_word("fetch", e, FETCH_WORD);
    endtask

    initial begin
        num_errors = 0;
        compares = 0;
        cycles = 0;
        RST = 1'b1;
        WDT_TIMEOUT = 1'b0;
        FETCH_ADDR = 11'h000;
        void'($urandom(32'h111d_e5cc));
        cyc(3);
        RST = 1'b0;
        // Core blanks program memory after reset
        cyc(2100);
        chk_bit("oe", 1'b0, PROG_DAT_OE);
        prog.enter(1'b1);
        chk_bit("mode", 1'b0, PROG_MODE);
        prog.leave();
        WDT_TIMEOUT = 1'b1;
        cyc(2);
        chk_bit("wdt", 1'b1, WDT_RESET);
        prog.enter(1'b0);
        chk_bit("mode", 1'b1, PROG_MODE);
        chk_bit("wdt", 1'b0, WDT_RESET);
        rd_chk("blank", BLANK_WORD);
        // An unknown command is taken whole and ignored
        prog.xfer(6'h3F, 14'h0000, 0, rd);
        for (int a = 0; a < 4; a++) begin
            exp_mem[a] = int'($urandom & 32'h0000_3FFF);
            wr(CMD_LOAD_DATA, 14'(exp_mem[a]));
            rd_chk("prog", 14'(exp_mem[a]));
            step(1);
        end
        prog.leave();
        cyc(2);
        chk_bit("wdt", 1'b1, WDT_RESET);
        WDT_TIMEOUT = 1'b0;
        prog.enter(1'b0);
        rd_chk("entry", 14'(exp_mem[0]));
        for (int i = 0; i < 4; i++) begin
            // Only the low nibble carries content
            ids[i] = 14'($urandom & 32'h0000_000F);
            wr(i == 0 ? CMD_LOAD_CFG : CMD_LOAD_DATA, ids[i]);
            rd_chk("id", ids[i]);
            step(1);
        end
        step(3);
        rd_chk("cfg", CFG_RESET);
        cfg = CFG_RESET & ~(14'h0003 << CP_LSB);
        wr(CMD_LOAD_DATA, cfg);
        rd_chk("cfg", cfg);
        prog.leave();
        for (int a = 0; a < 4; a++) begin
            fetch_chk(a, 14'(exp_mem[a]));
        end
        prog.enter(1'b0);
        rd_chk("prot", PROT_WORD);
        prog.xfer(CMD_ERASE, 14'h0000, 0, rd);
        cyc(2200);
        // Load-config moves the counter and loads the latch here, nothing is committed
        prog.xfer(CMD_LOAD_CFG, 14'h0000, 1, rd);
        step(7);
        rd_chk("cfg", cfg);
        prog.leave();
        fetch_chk(0, BLANK_WORD);
        chk_word("drive", 14'h0000, 14'(prog.faults));
        stop_test();
    end
endmodule
`default_nettype wire
